// file: pwr_ctl_pkg.sv
// Constants, state codes and carrier types for the peripheral power-reduction controller.
// Assumes a device reached through a byte-wide register port on the same clock as this controller.
// Behaviour
// RULE1: Timer two gate bit is six; it stops that timer only in synchronous mode.
// RULE2: Timer zero gate bit is five; clearing it resumes the frozen timer.
// RULE3: Timer one gate bit is three; clearing it resumes the frozen timer.
// RULE4: Serial peripheral gate is bit two; reinitialise after ungating.
// RULE5: Async serial gate is bit one; reinitialise after ungating.
// RULE6: Reserved gate bits, including bits four and zero of first, read zero.
// RULE7: Second gate register sits at 0x65 and resets to all zeros.
// RULE8: Keyboard gate is second-register bit five; reinitialise after ungating.
// RULE9: Cipher gate is second-register bit four; reinitialise after ungating.
// RULE10: Smartcard gate is second-register bit three; reinitialise after ungating.
// RULE11: Fast serial gate is second-register bit two; reinitialise after ungating.
// RULE12: USB device gate is second-register bit one; reinitialise after ungating.
// RULE13: USB host gate is second-register bit zero; reinitialise after ungating.
// RULE14: Gated USB host blocks USB cards; clocked smartcard unit keeps contact cards usable.
// RULE15: Power-down leaves PLL source and converter untouched until software changes them.
// RULE16: Before power-down clear PLL source, clear PLL on, poll lock to zero.
// RULE17: Clearing converter on bit starts shutdown; wait for ready flag zero.
// RULE18: After PLL stops, write prescale register to 0x00, no division.
// RULE19: Enabled brown-out detector stays active in every sleep mode.
// RULE20: Enabled watchdog keeps running in every sleep mode.
// RULE21: Programmed debug fuse keeps main clock source on during sleep.
// RULE22: Debug is off if either fuse unprogrammed or scan-port disable bit written.
// RULE23: Gated peripheral state freezes, registers inaccessible, state restored on ungating.
// RULE24: Two-wire gate is first-register bit seven; reinitialise after ungating.
package pwr_ctl_pkg;

  // Device register map.
  localparam logic [7:0] DEV_GATE_FIRST = 8'h64;
  localparam logic [7:0] DEV_GATE_SECOND = 8'h65;
  localparam logic [7:0] DEV_PLL_CTRL = 8'h40;
  localparam logic [7:0] DEV_CONV_CTRL = 8'h41;
  localparam logic [7:0] DEV_PRESCALE = 8'h42;
  localparam logic [7:0] DEV_MCU_CTRL = 8'h43;

  // Gate bit positions.
  localparam int GATE_TWO_WIRE = 7;
  localparam int GATE_TIMER_TWO = 6;
  localparam int GATE_TIMER_ZERO = 5;
  localparam int GATE_TIMER_ONE = 3;
  localparam int GATE_SERIAL_PERIPH = 2;
  localparam int GATE_ASYNC_SERIAL = 1;
  localparam int GATE_KEYBOARD = 5;
  localparam int GATE_CIPHER = 4;
  localparam int GATE_SMARTCARD = 3;
  localparam int GATE_FAST_SERIAL = 2;
  localparam int GATE_USB_DEVICE = 1;
  localparam int GATE_USB_HOST = 0;
  localparam logic [7:0] GATE_FIRST_MASK = 8'hEE;
  localparam logic [7:0] GATE_SECOND_MASK = 8'h3F;
  localparam logic [7:0] GATE_RESET = 8'h00;

  // Clock, converter and control bit positions.
  localparam int PLL_SOURCE_SELECT = 1;
  localparam int PLL_ON = 0;
  localparam int PLL_LOCK = 2;
  localparam int CONVERTER_ON_BIT = 0;
  localparam int CONVERTER_READY_FLAG = 1;
  localparam int SCAN_PORT_DISABLE_BIT = 7;
  localparam logic [7:0] PRESCALE_NONE = 8'h00;

  // Controller registers seen by software.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_GATE_FIRST = 8'h01;
  localparam logic [7:0] REG_GATE_SECOND = 8'h02;
  localparam logic [7:0] REG_STATUS = 8'h03;
  localparam logic [7:0] REG_REINIT_FIRST = 8'h04;
  localparam logic [7:0] REG_REINIT_SECOND = 8'h05;
  localparam int CMD_APPLY = 0;
  localparam int CMD_PREP = 1;
  localparam int CMD_DEBUG_OFF = 2;
  localparam logic [15:0] POLL_LIMIT_DEFAULT = 16'h0400;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dev_req_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_GATE_A = 4'b0001,
    ST_GATE_B = 4'b0010,
    ST_PLL_RD = 4'b0011,
    ST_PLL_MUX = 4'b0100,
    ST_PLL_OFF = 4'b0101,
    ST_LOCK_RD = 4'b0110,
    ST_PRESCALE = 4'b0111,
    ST_DC_RD = 4'b1000,
    ST_DC_OFF = 4'b1001,
    ST_RDY_RD = 4'b1010,
    ST_MCU_RD = 4'b1011,
    ST_MCU_WR = 4'b1100
  } seq_state_e;

endpackage

// file: pwr_dev_port.sv
// Single-access engine toward the device register port.
// Assumes device read data stand in the cycle after the read strobe, on the same clock.
`timescale 1ns/1ps
module pwr_dev_port
  import pwr_ctl_pkg::*;
(
  input wire logic i_ref_clk, // System clock.
  input wire logic i_rst_sync_n, // Synchronised reset, active low.
  input wire logic i_ce, // Clock enable.
  input wire logic i_req_valid, // One-cycle access request.
  input wire dev_req_s i_req, // Access kind, address and data.
  output logic o_ack, // One-cycle completion pulse.
  output logic [7:0] o_rdata, // Read data, valid with o_ack.
  output logic [7:0] o_dev_addr, // Device register address.
  output logic [7:0] o_dev_wdata, // Device write data.
  output logic o_dev_wr, // Device write strobe.
  output logic o_dev_rd, // Device read strobe.
  input wire logic [7:0] i_dev_rdata // Device read data.
);

  typedef struct packed {
    logic [1:0] phase;
    dev_req_s req;
    logic [7:0] rdata;
    logic ack;
  } port_state_s;

  port_state_s st_r;
  port_state_s st_nxt;

  // Phase 1 carries the strobe, phase 2 samples the answer, the ack follows.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    case (st_r.phase)
      2'h0:
      begin
        if (i_req_valid)
        begin
          st_nxt.req = i_req;
          st_nxt.phase = 2'h1;
        end
      end
      2'h1: st_nxt.phase = 2'h2;
      2'h2:
      begin
        st_nxt.rdata = i_dev_rdata;
        st_nxt.ack = 1'b1;
        st_nxt.phase = 2'h0;
      end
      default: st_nxt.phase = 2'h0;
    endcase
  end

  // Freezing with i_ce low would stretch a strobe, so callers hold i_ce high during accesses.
  always_ff @(posedge i_ref_clk or negedge i_rst_sync_n)
  begin
    if (!i_rst_sync_n)
      st_r <= '0;
    else if (i_ce)
      st_r <= st_nxt;
  end

  // Strobes decode from the registered phase so they last exactly one cycle.
  assign o_dev_wr = (st_r.phase == 2'h1) && st_r.req.we;
  assign o_dev_rd = (st_r.phase == 2'h1) && !st_r.req.we;
  assign o_dev_addr = st_r.req.addr;
  assign o_dev_wdata = st_r.req.wdata;
  assign o_ack = st_r.ack;
  assign o_rdata = st_r.rdata;

endmodule

// file: pwr_gate_ctl.sv
// Power-reduction controller: writes the device gate registers, runs the power-down preparation.
// Assumes the device register port answers reads one cycle after the strobe and never stalls.
`timescale 1ns/1ps
module pwr_gate_ctl
  import pwr_ctl_pkg::*;
#(
  parameter logic [15:0] POLL_LIMIT = POLL_LIMIT_DEFAULT
)
(
  input wire logic i_ref_clk, // 100 MHz system clock.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_ce, // Clock enable, freezes all state except the two-flop reset synchroniser when low.
  input wire logic [7:0] i_addr, // Software register address.
  input wire logic [7:0] i_wr_data, // Software write data.
  input wire logic i_wr, // Software write strobe.
  input wire logic i_rd, // Software read strobe.
  output logic [7:0] o_rd_data, // Read data, one cycle after i_rd.
  output logic [7:0] o_dev_addr, // Device register address.
  output logic [7:0] o_dev_wdata, // Device write data.
  output logic o_dev_wr, // Device write strobe.
  output logic o_dev_rd, // Device read strobe.
  input wire logic [7:0] i_dev_rdata, // Device read data.
  output logic o_busy // A sequence is in progress.
);

  typedef struct packed {
    seq_state_e state;
    logic wait_ack;
    logic [7:0] gate0;
    logic [7:0] gate1;
    logic [7:0] snap0;
    logic [7:0] snap1;
    logic [7:0] app0;
    logic [7:0] app1;
    logic [7:0] reinit0;
    logic [7:0] reinit1;
    logic [7:0] tmp;
    logic [15:0] poll_cnt;
    logic prep_done;
    logic timeout;
    logic [7:0] rd_data;
  } ctl_state_s;

  ctl_state_s st_r;
  ctl_state_s st_nxt;
  logic [1:0] rst_sync_r;
  logic rst_sync_n;
  logic req_valid;
  dev_req_s req;
  logic ack;
  logic [7:0] ack_data;
  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] clr0;
  logic [7:0] clr1;
  logic [7:0] status;

  // Reset is released through two flops so every state flop leaves reset on the same edge.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_sync_n = rst_sync_r[1];

  pwr_dev_port u_port (
    .i_ref_clk(i_ref_clk),
    .i_rst_sync_n(rst_sync_n),
    .i_ce(i_ce),
    .i_req_valid(req_valid),
    .i_req(req),
    .o_ack(ack),
    .o_rdata(ack_data),
    .o_dev_addr(o_dev_addr),
    .o_dev_wdata(o_dev_wdata),
    .o_dev_wr(o_dev_wr),
    .o_dev_rd(o_dev_rd),
    .i_dev_rdata(i_dev_rdata)
  );

  // Each access state issues one request and then waits for its ack.
  always_comb
  begin
    req_valid = (st_r.state != ST_IDLE) && !st_r.wait_ack;
    req = '0;
    case (st_r.state)
      ST_GATE_A: req = '{we: 1'b1, addr: DEV_GATE_FIRST, wdata: st_r.snap0}; // see RULE6
      ST_GATE_B: req = '{we: 1'b1, addr: DEV_GATE_SECOND, wdata: st_r.snap1}; // see RULE7
      ST_PLL_RD: req = '{we: 1'b0, addr: DEV_PLL_CTRL, wdata: 8'h00};
      ST_PLL_MUX: req = '{we: 1'b1, addr: DEV_PLL_CTRL, wdata: st_r.tmp}; // see RULE16
      ST_PLL_OFF: req = '{we: 1'b1, addr: DEV_PLL_CTRL, wdata: st_r.tmp}; // see RULE16
      ST_LOCK_RD: req = '{we: 1'b0, addr: DEV_PLL_CTRL, wdata: 8'h00};
      ST_PRESCALE: req = '{we: 1'b1, addr: DEV_PRESCALE, wdata: PRESCALE_NONE}; // see RULE18
      ST_DC_RD: req = '{we: 1'b0, addr: DEV_CONV_CTRL, wdata: 8'h00};
      ST_DC_OFF: req = '{we: 1'b1, addr: DEV_CONV_CTRL, wdata: st_r.tmp}; // see RULE17
      ST_RDY_RD: req = '{we: 1'b0, addr: DEV_CONV_CTRL, wdata: 8'h00};
      ST_MCU_RD: req = '{we: 1'b0, addr: DEV_MCU_CTRL, wdata: 8'h00};
      ST_MCU_WR: req = '{we: 1'b1, addr: DEV_MCU_CTRL, wdata: st_r.tmp}; // see RULE22
      default: req = '0;
    endcase
  end

  // Status shows sequence progress and which smart-card paths the applied gates leave open.
  always_comb
  begin
    status = 8'h00;
    status[0] = st_r.state != ST_IDLE;
    status[1] = st_r.prep_done;
    status[2] = st_r.timeout;
    status[3] = !st_r.app1[GATE_USB_HOST]; // see RULE14
    status[4] = !st_r.app1[GATE_SMARTCARD]; // see RULE14
  end

  // A gate bit going from one to zero asks software to reinitialise that unit.
  always_comb
  begin
    set0 = 8'h00;
    set1 = 8'h00;
    clr0 = 8'h00;
    clr1 = 8'h00;
    if (ack && st_r.state == ST_GATE_A)
      set0 = st_r.app0 & ~st_r.snap0; // see RULE4, RULE5, RULE24
    if (ack && st_r.state == ST_GATE_B)
      set1 = st_r.app1 & ~st_r.snap1; // see RULE8, RULE9, RULE10, RULE11, RULE12, RULE13
    if (i_wr && i_addr == REG_REINIT_FIRST)
      clr0 = i_wr_data;
    if (i_wr && i_addr == REG_REINIT_SECOND)
      clr1 = i_wr_data;
  end

  // Main next-state logic: software port, sequencer and sticky flags.
  always_comb
  begin
    st_nxt = st_r;
    if (req_valid)
      st_nxt.wait_ack = 1'b1;
    // Set wins over a same-cycle write-one clear.
    st_nxt.reinit0 = (st_r.reinit0 & ~clr0) | set0;
    st_nxt.reinit1 = (st_r.reinit1 & ~clr1) | set1;
    if (i_wr && i_addr == REG_GATE_FIRST)
      st_nxt.gate0 = i_wr_data & GATE_FIRST_MASK; // see RULE6
    if (i_wr && i_addr == REG_GATE_SECOND)
      st_nxt.gate1 = i_wr_data & GATE_SECOND_MASK; // see RULE6
    if (i_rd)
    begin
      case (i_addr)
        REG_GATE_FIRST: st_nxt.rd_data = st_r.gate0;
        REG_GATE_SECOND: st_nxt.rd_data = st_r.gate1;
        REG_STATUS: st_nxt.rd_data = status;
        REG_REINIT_FIRST: st_nxt.rd_data = st_r.reinit0;
        REG_REINIT_SECOND: st_nxt.rd_data = st_r.reinit1;
        default: st_nxt.rd_data = 8'h00;
      endcase
    end
    // Commands are ignored while a sequence runs; apply wins over prep, prep over debug off.
    if (i_wr && i_addr == REG_CMD && st_r.state == ST_IDLE)
    begin
      if (i_wr_data[CMD_APPLY])
      begin
        st_nxt.snap0 = st_r.gate0;
        st_nxt.snap1 = st_r.gate1;
        st_nxt.state = ST_GATE_A; // see RULE1, RULE2, RULE3, RULE23
      end
      else if (i_wr_data[CMD_PREP])
      begin
        st_nxt.prep_done = 1'b0;
        st_nxt.timeout = 1'b0;
        st_nxt.state = ST_PLL_RD; // see RULE15
      end
      else if (i_wr_data[CMD_DEBUG_OFF])
        st_nxt.state = ST_MCU_RD;
    end
    if (ack)
    begin
      st_nxt.wait_ack = 1'b0;
      case (st_r.state)
        ST_GATE_A:
        begin
          st_nxt.app0 = st_r.snap0;
          st_nxt.state = ST_GATE_B;
        end
        ST_GATE_B:
        begin
          st_nxt.app1 = st_r.snap1;
          st_nxt.state = ST_IDLE;
        end
        ST_PLL_RD:
        begin
          // Source select goes to the external clock first, before the PLL is stopped.
          st_nxt.tmp = ack_data;
          st_nxt.tmp[PLL_SOURCE_SELECT] = 1'b0; // see RULE16
          st_nxt.state = ST_PLL_MUX;
        end
        ST_PLL_MUX:
        begin
          st_nxt.tmp[PLL_ON] = 1'b0; // see RULE16
          st_nxt.poll_cnt = 16'h0000;
          st_nxt.state = ST_PLL_OFF;
        end
        ST_PLL_OFF: st_nxt.state = ST_LOCK_RD;
        ST_LOCK_RD:
        begin
          if (!ack_data[PLL_LOCK])
            st_nxt.state = ST_PRESCALE; // see RULE16
          else if (st_r.poll_cnt == POLL_LIMIT)
          begin
            st_nxt.timeout = 1'b1;
            st_nxt.state = ST_IDLE;
          end
          else
            st_nxt.poll_cnt = st_r.poll_cnt + 16'h0001;
        end
        ST_PRESCALE: st_nxt.state = ST_DC_RD;
        ST_DC_RD:
        begin
          st_nxt.tmp = ack_data;
          st_nxt.tmp[CONVERTER_ON_BIT] = 1'b0; // see RULE17
          st_nxt.state = ST_DC_OFF;
        end
        ST_DC_OFF:
        begin
          st_nxt.poll_cnt = 16'h0000;
          st_nxt.state = ST_RDY_RD;
        end
        ST_RDY_RD:
        begin
          if (!ack_data[CONVERTER_READY_FLAG])
          begin
            st_nxt.prep_done = 1'b1; // see RULE17
            st_nxt.state = ST_IDLE;
          end
          else if (st_r.poll_cnt == POLL_LIMIT)
          begin
            st_nxt.timeout = 1'b1;
            st_nxt.state = ST_IDLE;
          end
          else
            st_nxt.poll_cnt = st_r.poll_cnt + 16'h0001;
        end
        ST_MCU_RD:
        begin
          // Writing the scan-port disable bit turns on-chip debug off.
          st_nxt.tmp = ack_data;
          st_nxt.tmp[SCAN_PORT_DISABLE_BIT] = 1'b1; // see RULE22
          st_nxt.state = ST_MCU_WR;
        end
        ST_MCU_WR: st_nxt.state = ST_IDLE;
        default: st_nxt.state = ST_IDLE;
      endcase
    end
  end

  // Gates reset to zero, so every peripheral is clocked until software applies a mask.
  always_ff @(posedge i_ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st_r <= '0;
      st_r.state <= ST_IDLE;
      st_r.gate0 <= GATE_RESET;
      st_r.gate1 <= GATE_RESET; // see RULE7
      st_r.app0 <= GATE_RESET;
      st_r.app1 <= GATE_RESET;
    end
    else if (i_ce)
      st_r <= st_nxt;
  end

  assign o_rd_data = st_r.rd_data;
  assign o_busy = st_r.state != ST_IDLE;

endmodule

// file: pwr_gate_ctl_asserts.sv
// Checker for the power-reduction controller, bound to its top module.
// Assumes the device port and software port keep the hand-over timing.
`timescale 1ns/1ps
module pwr_gate_ctl_asserts
  import pwr_ctl_pkg::*;
#(
  parameter logic [15:0] POLL_LIMIT = POLL_LIMIT_DEFAULT
)
(
  input wire logic i_ref_clk, // Clock.
  input wire logic i_rst_n, // Reset, active low.
  input wire logic i_ce, // Clock enable.
  input wire logic [7:0] i_addr, // Address.
  input wire logic [7:0] i_wr_data, // Write data.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  input wire logic [7:0] o_rd_data, // Read data.
  input wire logic [7:0] o_dev_addr, // Device address.
  input wire logic [7:0] o_dev_wdata, // Device write data.
  input wire logic o_dev_wr, // Device write strobe.
  input wire logic o_dev_rd, // Device read strobe.
  input wire logic [7:0] i_dev_rdata, // Device read data.
  input wire logic o_busy // Busy.
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic cmd_go;
  logic dstb;
  // A command only counts when the controller is idle, since busy refuses it.
  assign cmd_go = i_ce && i_wr && i_addr == REG_CMD && !o_busy;
  assign dstb = o_dev_wr || o_dev_rd;
  sequence s_gate_first;
    o_dev_wr && o_dev_addr == DEV_GATE_FIRST;
  endsequence
  sequence s_gate_second;
    o_dev_wr && o_dev_addr == DEV_GATE_SECOND;
  endsequence
  a_apply_pair: assert property (cmd_go && i_wr_data[CMD_APPLY] |-> ##2 s_gate_first ##4 s_gate_second)
    else $error("gate writes late or out of order");
  a_busy_hold: assert property (cmd_go && |i_wr_data[2:0] |=> o_busy [*3])
    else $error("busy not held after command");
  a_strobe_gap: assert property (dstb |=> !dstb [*3])
    else $error("device strobes too close");
  a_first_mask: assert property (s_gate_first |-> (o_dev_wdata & ~GATE_FIRST_MASK) == 8'h00)
    else $error("reserved first gate bit written");
  a_second_mask: assert property (s_gate_second |-> (o_dev_wdata & ~GATE_SECOND_MASK) == 8'h00)
    else $error("reserved second gate bit written");
  a_pll_source: assert property (o_dev_wr && o_dev_addr == DEV_PLL_CTRL |-> !o_dev_wdata[PLL_SOURCE_SELECT])
    else $error("pll source left selected");
  a_conv_off: assert property (o_dev_wr && o_dev_addr == DEV_CONV_CTRL |-> !o_dev_wdata[CONVERTER_ON_BIT])
    else $error("converter left on");
  a_prescale_none: assert property (o_dev_wr && o_dev_addr == DEV_PRESCALE |-> o_dev_wdata == PRESCALE_NONE)
    else $error("prescale not cleared");
  a_debug_off: assert property (o_dev_wr && o_dev_addr == DEV_MCU_CTRL |-> o_dev_wdata[SCAN_PORT_DISABLE_BIT])
    else $error("scan disable bit not set");
  a_unmapped_zero: assert property (i_ce && i_rd && i_addr > REG_REINIT_SECOND |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind pwr_gate_ctl pwr_gate_ctl_asserts #(.POLL_LIMIT(POLL_LIMIT)) pwr_gate_ctl_asserts_inst (.i_ref_clk, .i_rst_n,
  .i_ce, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .o_dev_addr, .o_dev_wdata, .o_dev_wr, .o_dev_rd,
  .i_dev_rdata, .o_busy);

// file: pwr_dev_model.sv
// Behavioural device: gate, PLL, converter, prescale and MCU control registers.
// Assumes one clock with the controller; read data stand only in the cycle after the strobe.
`timescale 1ns/1ps
module pwr_dev_model
  import pwr_ctl_pkg::*;
(
  input wire logic i_ref_clk, // Clock.
  input wire logic i_rst_n, // Reset, active low.
  input wire logic [7:0] i_addr, // Register address.
  input wire logic [7:0] i_wdata, // Write data.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  input wire logic [3:0] i_dly, // Cycles before lock and ready fall; 15 means never.
  output logic [7:0] o_rdata, // Read data.
  output logic [5:0][7:0] o_regs // Mcu, prescale, converter, pll, second gate, first gate.
);
  localparam logic [5:0][7:0] WMASK = {8'hFF, 8'hFF, 8'h01, 8'h03, 8'h3F, 8'hEE};
  logic [2:0] idx;
  logic [7:0] q;
  logic rv;
  logic [3:0] pc;
  logic [3:0] cc;
  // Outside the answer cycle the bus shows the inverse, so a late sample never matches.
  assign o_rdata = rv ? q : ~q;
  // Address decode; anything else is unmapped.
  always_comb
    case (i_addr)
      DEV_GATE_FIRST: idx = 3'h0;
      DEV_GATE_SECOND: idx = 3'h1;
      DEV_PLL_CTRL: idx = 3'h2;
      DEV_CONV_CTRL: idx = 3'h3;
      DEV_PRESCALE: idx = 3'h4;
      DEV_MCU_CTRL: idx = 3'h5;
      default: idx = 3'h6;
    endcase
  // Only software moves the PLL and converter controls; lock and ready follow them.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_regs <= {8'h00, 8'h03, 8'h03, 8'h07, 8'h00, 8'h00};
      rv <= 1'b0;
      q <= 8'h00;
      pc <= 4'h0;
      cc <= 4'h0;
    end
    else
    begin
      rv <= i_rd;
      if (i_rd)
        q <= (idx == 3'h6) ? 8'h00 : o_regs[idx];
      // Reserved bits never take a one.
      if (i_wr && idx != 3'h6)
        o_regs[idx] <= (o_regs[idx] & ~WMASK[idx]) | (i_wdata & WMASK[idx]);
      if (o_regs[2][0])
        pc <= 4'h0;
      else if (o_regs[2][2] && i_dly != 4'hF)
        pc <= pc + 4'h1;
      o_regs[2][2] <= o_regs[2][0] || (o_regs[2][2] && pc != i_dly);
      if (o_regs[3][0])
        cc <= 4'h0;
      else if (o_regs[3][1] && i_dly != 4'hF)
        cc <= cc + 4'h1;
      o_regs[3][1] <= o_regs[3][0] || (o_regs[3][1] && cc != i_dly);
    end
endmodule

// file: tb_pwr_gate_ctl.sv
// Self-checking bench for the power-reduction controller with a behavioural device.
// Assumes the checker binds itself and the device model answers on the device port.
`timescale 1ns/1ps
module tb_pwr_gate_ctl;
  import pwr_ctl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic i_ce = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] dly = 4'h2;
  logic [7:0] o_rd_data, o_dev_addr, o_dev_wdata, dev_rdata, a0, a1, ri0, ri1, r;
  logic o_dev_wr, o_dev_rd, o_busy;
  logic rd_seen = 1'b0;
  logic [5:0][7:0] regs;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'd66157;
  int n_fail = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  pwr_gate_ctl #(.POLL_LIMIT(16'h0004)) pwr_gate_ctl_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(i_ce),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .o_dev_addr(o_dev_addr), .o_dev_wdata(o_dev_wdata), .o_dev_wr(o_dev_wr), .o_dev_rd(o_dev_rd),
    .i_dev_rdata(dev_rdata), .o_busy(o_busy));
  pwr_dev_model pwr_dev_model_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(o_dev_addr),
    .i_wdata(o_dev_wdata), .i_wr(o_dev_wr), .i_rd(o_dev_rd), .i_dly(dly), .o_rdata(dev_rdata), .o_regs(regs));
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function logic [7:0] st(input logic [2:0] f);
    return {3'h0, ~a1[3], ~a1[0], f};
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus cycle; every signal is set once per edge, so back-to-back calls never race.
  task op(input logic w, input logic rr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    i_ce <= ce;
    i_wr <= w;
    i_rd <= rr;
    i_addr <= a;
    i_wr_data <= d;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    if (ce)
      exp_q.push_back(e);
    op(1'b0, 1'b1, a, rnd());
  endtask
  task idle(input int n);
    repeat (n) op(1'b0, 1'b0, rnd(), rnd());
  endtask
  task wt();
    int k;
    k = 0;
    idle(2);
    #1;
    while (o_busy !== 1'b0 && k < 400)
    begin
      idle(1);
      #1;
      k++;
    end
    chk({7'h00, o_busy}, 8'h00);
  endtask
  task apply(input logic [7:0] n0, input logic [7:0] n1);
    op(1'b1, 1'b0, REG_GATE_FIRST, n0);
    op(1'b1, 1'b0, REG_GATE_SECOND, n1);
    op(1'b1, 1'b0, REG_CMD, 8'h01);
    wt();
    ri0 = ri0 | (a0 & ~n0 & GATE_FIRST_MASK);
    ri1 = ri1 | (a1 & ~n1 & GATE_SECOND_MASK);
    a0 = n0 & GATE_FIRST_MASK;
    a1 = n1 & GATE_SECOND_MASK;
    chk(regs[0], a0);
    chk(regs[1], a1);
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Each read answer is compared with the oldest expectation in the cycle after the strobe.
  always @(posedge clk)
  begin
    if (rd_seen)
      chk(o_rd_data, exp_q.pop_front());
    rd_seen = i_rd && i_ce;
  end
  // A hang ends the run as a failure.
  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end
  // Main sequence.
  initial
  begin
    a0 = 8'h00;
    a1 = 8'h00;
    ri0 = 8'h00;
    ri1 = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    idle(3);
    rd(REG_GATE_FIRST, 8'h00);
    rd(REG_GATE_SECOND, 8'h00);
    rd(REG_STATUS, st(3'h0));
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      op(1'b1, 1'b0, REG_GATE_FIRST, 8'h01 << i);
      op(1'b1, 1'b0, REG_GATE_SECOND, r);
      op(1'b1, 1'b0, {5'h1F, i[2:0]}, 8'hFF);
      rd(REG_GATE_FIRST, (8'h01 << i) & GATE_FIRST_MASK);
      rd(REG_GATE_SECOND, r & GATE_SECOND_MASK);
      rd({5'h1F, i[2:0]}, 8'h00);
    end
    // A write with the clock enable low must leave the shadow untouched.
    ce = 1'b0;
    op(1'b1, 1'b0, REG_GATE_FIRST, 8'hFF);
    ce = 1'b1;
    rd(REG_GATE_FIRST, 8'h80);
    repeat (3) apply(rnd(), rnd());
    rd(REG_STATUS, st(3'h0));
    apply(8'h00, 8'h00);
    rd(REG_REINIT_FIRST, ri0);
    rd(REG_REINIT_SECOND, ri1);
    op(1'b1, 1'b0, REG_REINIT_FIRST, 8'hFF);
    op(1'b1, 1'b0, REG_REINIT_SECOND, 8'hFF);
    rd(REG_REINIT_FIRST, 8'h00);
    rd(REG_REINIT_SECOND, 8'h00);
    // A second command while busy is dropped, so the PLL stays as it was.
    op(1'b1, 1'b0, REG_CMD, 8'h04);
    op(1'b1, 1'b0, REG_CMD, 8'h02);
    rd(REG_STATUS, st(3'h1));
    wt();
    chk({7'h00, regs[5][7]}, 8'h01);
    chk(regs[2], 8'h07);
    r = rnd();
    dly <= {1'b0, r[2:0]};
    op(1'b1, 1'b0, REG_CMD, 8'h02);
    wt();
    chk(regs[2], 8'h00);
    chk(regs[3], 8'h00);
    chk(regs[4], PRESCALE_NONE);
    chk(regs[1], a1);
    rd(REG_STATUS, st(3'h2));
    idle(2);
    // Reset while the controller is idle, then a lock that never falls must end in a timeout.
    rst_n <= 1'b0;
    dly <= 4'hF;
    idle(2);
    rst_n <= 1'b1;
    a1 = 8'h00;
    idle(3);
    op(1'b1, 1'b0, REG_CMD, 8'h02);
    wt();
    rd(REG_STATUS, st(3'h4));
    chk(regs[4], 8'h03);
    rd(REG_REINIT_FIRST, 8'h00);
    idle(3);
    close_out();
  end
endmodule
